//--- pll_cfg_pkg.sv
// Package with register map, field layout and reset values of the loop bank
package pll_cfg_pkg;

  // Register addresses as seen on the control port
  localparam logic [9:0] ADDR_PUMP_LOOP   = 10'h010;  // Pump mode, loop power
  localparam logic [9:0] ADDR_REF_LOW     = 10'h011;  // Reference divider 7:0
  localparam logic [9:0] ADDR_REF_HIGH    = 10'h012;  // Reference divider 13:8
  localparam logic [9:0] ADDR_FB_PRESCALE = 10'h013;  // Feedback prescale count
  localparam logic [9:0] ADDR_FB_LOW      = 10'h014;  // Feedback main 7:0
  localparam logic [9:0] ADDR_FB_HIGH     = 10'h015;  // Feedback main 12:8
  localparam logic [9:0] ADDR_CNT_CTRL    = 10'h016;  // Counter hold controls

  // Values after reset
  localparam logic [7:0] RST_PUMP_LOOP    = 8'h7D;    // Normal pump, async pd
  localparam logic [7:0] RST_REF_LOW      = 8'h01;
  localparam logic [7:0] RST_REF_HIGH     = 8'h00;
  localparam logic [7:0] RST_FB_PRESCALE  = 8'h00;
  localparam logic [7:0] RST_FB_LOW       = 8'h03;
  localparam logic [7:0] RST_FB_HIGH      = 8'h00;
  localparam logic [7:0] RST_CNT_CTRL     = 8'h00;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] MASK_PUMP_LOOP   = 8'hFF;
  localparam logic [7:0] MASK_REF_LOW     = 8'hFF;
  localparam logic [7:0] MASK_REF_HIGH    = 8'h3F;
  localparam logic [7:0] MASK_FB_PRESCALE = 8'h3F;
  localparam logic [7:0] MASK_FB_LOW      = 8'hFF;
  localparam logic [7:0] MASK_FB_HIGH     = 8'h1F;
  localparam logic [7:0] MASK_CNT_CTRL    = 8'h70;

  // Field positions
  localparam int PUMP_MODE_LSB   = 2;   // Pump drive mode at 3:2
  localparam int LOOP_PWR_LSB    = 0;   // Loop power state at 1:0
  localparam int HOLD_REF_BIT    = 6;   // Hold reference counter in reset
  localparam int HOLD_FB_BIT     = 5;   // Hold feedback counters in reset
  localparam int HOLD_ALL_BIT    = 4;   // Hold every counter in reset

  // Unmapped reads answer with this value
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // Pump drive mode codes
  typedef enum logic [1:0] {
    PUMP_HIZ    = 2'h0,
    PUMP_SOURCE = 2'h1,
    PUMP_SINK   = 2'h2,
    PUMP_NORMAL = 2'h3
  } pump_mode_t;

  // Loop power state codes
  typedef enum logic [1:0] {
    LOOP_RUN      = 2'h0,
    LOOP_ASYNC_PD = 2'h1,
    LOOP_UNUSED   = 2'h2,
    LOOP_SYNC_PD  = 2'h3
  } loop_pwr_t;

  // One access from the serial control port
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [9:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } reg_req_t;

  // State of one register cell
  typedef struct packed {
    logic [7:0] value;
  } cell_state_t;

  // State of the bank's read path
  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } bank_state_t;

endpackage : pll_cfg_pkg

//--- cfg_byte_cell.sv
// One byte-wide configuration register with reset value and write mask
`timescale 1ns/100ps
module cfg_byte_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,  // Value after reset
  parameter logic [7:0] WR_MASK   = 8'hFF   // Bits that software may set
) (
  input  wire logic       core_clk_i,  // Core clock
  input  wire logic       rst_i,       // Asynchronous reset, active high
  input  wire logic       wr_i,        // Write this register
  input  wire logic [7:0] wdata_i,     // Write data
  output logic      [7:0] value_o      // Stored value
);

  pll_cfg_pkg::cell_state_t st_r;    // Registered state
  pll_cfg_pkg::cell_state_t st_nxt;  // Next state

  // Masked bits are forced to zero so reserved bits always read as zero
  always_comb begin
    st_nxt = st_r;
    if (wr_i) begin
      st_nxt.value = wdata_i & WR_MASK;
    end
  end

  // Reset loads the constant parameter masked by WR_MASK
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.value <= RESET_VAL & WR_MASK;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value_o = st_r.value;

endmodule : cfg_byte_cell

//--- pll_divider_mode_registers.sv
// Loop configuration bank: pump mode, loop power and divider counts
`timescale 1ns/100ps
module pll_divider_mode_registers (
  input  wire logic                  core_clk_i,         // Core clock 20 MHz
  input  wire logic                  rst_i,              // Async reset, high
  input  wire pll_cfg_pkg::reg_req_t req_i,              // Port access
  output logic                       rvalid_o,           // Read data valid
  output logic                [7:0]  rdata_o,            // Read data
  output logic                [1:0]  pump_drive_mode_o,  // Pump mode field
  output logic                       pump_hiz_o,         // Pump off
  output logic                       pump_force_src_o,   // Pump up forced
  output logic                       pump_force_sink_o,  // Pump down forced
  output logic                [1:0]  loop_pwr_state_o,   // Loop power field
  output logic                       loop_run_o,         // Loop may run
  output logic                       loop_async_pd_o,    // Immediate pd
  output logic                       loop_sync_pd_o,     // Synchronous pd
  output logic                [13:0] ref_div_count_o,    // Reference divider
  output logic                [5:0]  fb_prescale_o,      // Prescale count
  output logic                [12:0] fb_main_count_o,    // Main count
  output logic                       ref_hold_rst_o,     // Hold ref counter
  output logic                       fb_hold_rst_o       // Hold fb counters
);

  // Stored register values
  logic [7:0] pump_loop_q;     // Pump and loop power control
  logic [7:0] ref_low_q;       // Reference divider low byte
  logic [7:0] ref_high_q;      // Reference divider high bits
  logic [7:0] fb_prescale_q;   // Feedback prescale count
  logic [7:0] fb_low_q;        // Feedback main low byte
  logic [7:0] fb_high_q;       // Feedback main high bits
  logic [7:0] cnt_ctrl_q;      // Counter hold controls

  // Per-register write enables
  logic       wr_pump_loop;
  logic       wr_ref_low;
  logic       wr_ref_high;
  logic       wr_fb_prescale;
  logic       wr_fb_low;
  logic       wr_fb_high;
  logic       wr_cnt_ctrl;

  // Decoded field views
  logic [1:0] loop_code;       // Loop power code
  logic [1:0] pump_code;       // Pump mode code

  // Read path state
  pll_cfg_pkg::bank_state_t st_r;    // Registered read state
  pll_cfg_pkg::bank_state_t st_nxt;  // Next read state

  // Address decode for writes; an unmapped write is simply dropped
  always_comb begin
    wr_pump_loop   = req_i.wr && (req_i.addr == pll_cfg_pkg::ADDR_PUMP_LOOP);
    wr_ref_low     = req_i.wr && (req_i.addr == pll_cfg_pkg::ADDR_REF_LOW);
    wr_ref_high    = req_i.wr && (req_i.addr == pll_cfg_pkg::ADDR_REF_HIGH);
    wr_fb_prescale = req_i.wr &&
                     (req_i.addr == pll_cfg_pkg::ADDR_FB_PRESCALE);
    wr_fb_low      = req_i.wr && (req_i.addr == pll_cfg_pkg::ADDR_FB_LOW);
    wr_fb_high     = req_i.wr && (req_i.addr == pll_cfg_pkg::ADDR_FB_HIGH);
    wr_cnt_ctrl    = req_i.wr && (req_i.addr == pll_cfg_pkg::ADDR_CNT_CTRL);
  end

  // Pump mode and loop power share one byte
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_PUMP_LOOP),
    .WR_MASK   (pll_cfg_pkg::MASK_PUMP_LOOP)
  ) u_pump_loop (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_pump_loop),
    .wdata_i    (req_i.wdata),
    .value_o    (pump_loop_q)
  );

  // Reference divider low byte
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_REF_LOW),
    .WR_MASK   (pll_cfg_pkg::MASK_REF_LOW)
  ) u_ref_low (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_ref_low),
    .wdata_i    (req_i.wdata),
    .value_o    (ref_low_q)
  );

  // Reference divider high six bits
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_REF_HIGH),
    .WR_MASK   (pll_cfg_pkg::MASK_REF_HIGH)
  ) u_ref_high (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_ref_high),
    .wdata_i    (req_i.wdata),
    .value_o    (ref_high_q)
  );

  // Feedback prescale count, six bits
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_FB_PRESCALE),
    .WR_MASK   (pll_cfg_pkg::MASK_FB_PRESCALE)
  ) u_fb_prescale (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_fb_prescale),
    .wdata_i    (req_i.wdata),
    .value_o    (fb_prescale_q)
  );

  // Feedback main count low byte
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_FB_LOW),
    .WR_MASK   (pll_cfg_pkg::MASK_FB_LOW)
  ) u_fb_low (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_fb_low),
    .wdata_i    (req_i.wdata),
    .value_o    (fb_low_q)
  );

  // Feedback main count high five bits
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_FB_HIGH),
    .WR_MASK   (pll_cfg_pkg::MASK_FB_HIGH)
  ) u_fb_high (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_fb_high),
    .wdata_i    (req_i.wdata),
    .value_o    (fb_high_q)
  );

  // Counter hold controls; only bits 6:4 are kept
  cfg_byte_cell #(
    .RESET_VAL (pll_cfg_pkg::RST_CNT_CTRL),
    .WR_MASK   (pll_cfg_pkg::MASK_CNT_CTRL)
  ) u_cnt_ctrl (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_i       (wr_cnt_ctrl),
    .wdata_i    (req_i.wdata),
    .value_o    (cnt_ctrl_q)
  );

  // Field extraction
  assign pump_code = pump_loop_q[pll_cfg_pkg::PUMP_MODE_LSB +: 2];
  assign loop_code = pump_loop_q[pll_cfg_pkg::LOOP_PWR_LSB +: 2];

  // Pump decode; exactly one flag or normal pumping is active
  always_comb begin
    pump_hiz_o        = 1'b0;
    pump_force_src_o  = 1'b0;
    pump_force_sink_o = 1'b0;
    case (pump_code)
      pll_cfg_pkg::PUMP_HIZ:    pump_hiz_o        = 1'b1;
      pll_cfg_pkg::PUMP_SOURCE: pump_force_src_o  = 1'b1;
      pll_cfg_pkg::PUMP_SINK:   pump_force_sink_o = 1'b1;
      pll_cfg_pkg::PUMP_NORMAL: pump_hiz_o        = 1'b0;
      default:                  pump_hiz_o        = 1'b1;
    endcase
  end

  // Loop power decode; the unused code falls back to immediate power-down
  // so the loop is never left in an undefined mode
  always_comb begin
    loop_run_o      = 1'b0;
    loop_async_pd_o = 1'b0;
    loop_sync_pd_o  = 1'b0;
    case (loop_code)
      pll_cfg_pkg::LOOP_RUN:      loop_run_o      = 1'b1;
      pll_cfg_pkg::LOOP_ASYNC_PD: loop_async_pd_o = 1'b1;
      pll_cfg_pkg::LOOP_UNUSED:   loop_async_pd_o = 1'b1;
      pll_cfg_pkg::LOOP_SYNC_PD:  loop_sync_pd_o  = 1'b1;
      default:                    loop_async_pd_o = 1'b1;
    endcase
  end

  // Divider counts assembled from their byte registers
  assign ref_div_count_o   = {ref_high_q[5:0], ref_low_q};
  assign fb_prescale_o     = fb_prescale_q[5:0];
  assign fb_main_count_o   = {fb_high_q[4:0], fb_low_q};
  assign pump_drive_mode_o = pump_code;
  assign loop_pwr_state_o  = loop_code;

  // Counter holds; the all-counters bit holds both dividers
  assign ref_hold_rst_o = cnt_ctrl_q[pll_cfg_pkg::HOLD_REF_BIT] |
                          cnt_ctrl_q[pll_cfg_pkg::HOLD_ALL_BIT];
  assign fb_hold_rst_o  = cnt_ctrl_q[pll_cfg_pkg::HOLD_FB_BIT] |
                          cnt_ctrl_q[pll_cfg_pkg::HOLD_ALL_BIT];

  // Read mux; a read in the same cycle as a write returns the old value
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = req_i.rd;
    if (req_i.rd) begin
      case (req_i.addr)
        pll_cfg_pkg::ADDR_PUMP_LOOP:   st_nxt.rdata = pump_loop_q;
        pll_cfg_pkg::ADDR_REF_LOW:     st_nxt.rdata = ref_low_q;
        pll_cfg_pkg::ADDR_REF_HIGH:    st_nxt.rdata = ref_high_q;
        pll_cfg_pkg::ADDR_FB_PRESCALE: st_nxt.rdata = fb_prescale_q;
        pll_cfg_pkg::ADDR_FB_LOW:      st_nxt.rdata = fb_low_q;
        pll_cfg_pkg::ADDR_FB_HIGH:     st_nxt.rdata = fb_high_q;
        pll_cfg_pkg::ADDR_CNT_CTRL:    st_nxt.rdata = cnt_ctrl_q;
        default:                       st_nxt.rdata = pll_cfg_pkg::RDATA_NONE;
      endcase
    end
  end

  // Read state register; data holds until the next read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.rvalid <= 1'b0;
      st_r.rdata  <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rvalid_o = st_r.rvalid;
  assign rdata_o  = st_r.rdata;

  // Checks on the bank's behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  pump_write_a: assert property (
    (req_i.wr && req_i.addr == 10'h010) |=>
      pump_drive_mode_o == $past(req_i.wdata[3:2]) &&
      (pump_hiz_o == (pump_drive_mode_o == 2'h0)) &&
      (pump_force_sink_o == (pump_drive_mode_o == 2'h2)))
    else $error("pump mode not taken from write");

  pump_onehot_a: assert property (
    $countones({pump_hiz_o, pump_force_src_o, pump_force_sink_o}) ==
      ((pump_drive_mode_o == 2'h3) ? 0 : 1))
    else $error("pump mode decode wrong");

  loop_write_a: assert property (
    (req_i.wr && req_i.addr == 10'h010) |=>
      loop_pwr_state_o == $past(req_i.wdata[1:0]) &&
      loop_run_o == ($past(req_i.wdata[1:0]) == 2'h0))
    else $error("loop power state not taken from write");

  loop_unused_a: assert property (
    (loop_pwr_state_o == 2'h2) |-> (loop_async_pd_o && !loop_run_o))
    else $error("unused loop code does not power down");

  ref_low_a: assert property (
    (req_i.wr && req_i.addr == 10'h011) |=>
      ref_div_count_o[7:0] == $past(req_i.wdata) &&
      $stable(ref_div_count_o[13:8]))
    else $error("reference low byte write wrong");

  // A plain read of the high byte; no write may disturb the count meanwhile
  ref_high_a: assert property (
    (req_i.rd && req_i.addr == 10'h012 && !req_i.wr) |=>
      rdata_o == {2'b00, ref_div_count_o[13:8]} && rvalid_o)
    else $error("reference high readback wrong");

  ref_width_a: assert property (
    (req_i.wr && req_i.addr == 10'h012) |=>
      ref_div_count_o == {$past(req_i.wdata[5:0]), $past(ref_low_q)})
    else $error("reference divider assembly wrong");

  prescale_a: assert property (
    (req_i.wr && req_i.addr == 10'h013) |=>
      fb_prescale_o == $past(req_i.wdata[5:0]) && fb_prescale_q[7:6] == 2'b00)
    else $error("prescale write wrong");

  main_high_a: assert property (
    (req_i.wr && req_i.addr == 10'h015) |=>
      fb_main_count_o[12:8] == $past(req_i.wdata[4:0]) &&
      $stable(fb_main_count_o[7:0]))
    else $error("feedback main high write wrong");

  main_low_a: assert property (
    (req_i.wr && req_i.addr == 10'h014) |=>
      fb_main_count_o[7:0] == $past(req_i.wdata))
    else $error("feedback main low write wrong");

  ref_hold_a: assert property (
    (req_i.wr && req_i.addr == 10'h016) |=>
      ref_hold_rst_o == ($past(req_i.wdata[6]) || $past(req_i.wdata[4])))
    else $error("reference hold not following control bit");

  // Low byte reads back exactly what drives the divider
  ref_low_read_a: assert property (
    (req_i.rd && req_i.addr == 10'h011 && !req_i.wr) |=>
      rdata_o == ref_div_count_o[7:0] && rvalid_o)
    else $error("reference low readback wrong");

  // Upper main count bits read back with reserved bits as zero
  main_read_a: assert property (
    (req_i.rd && req_i.addr == 10'h015 && !req_i.wr) |=>
      rdata_o == {3'b000, fb_main_count_o[12:8]} && rvalid_o)
    else $error("feedback main high readback wrong");

  // Loop power field only moves on a write to its own register
  loop_keep_a: assert property (
    !(req_i.wr && req_i.addr == 10'h010) |=> $stable(loop_pwr_state_o))
    else $error("loop power state changed without write");

endmodule : pll_divider_mode_registers

//--- tb_top.sv
// Self-checking testbench for the loop configuration register bank
`timescale 1ns/100ps
module tb_top;
  logic                  core_clk_i = 1'b0;  // Core clock, 50 ns period
  logic                  rst_i      = 1'b1;  // Asynchronous reset
  pll_cfg_pkg::reg_req_t req        = '0;    // Control port request
  logic                  rvalid_o;           // Read data valid
  logic [7:0]            rdata_o;            // Read data
  logic [1:0]            pump_mode;          // Pump mode field
  logic                  pump_hiz;           // Pump off
  logic                  pump_src;           // Pump forced up
  logic                  pump_sink;          // Pump forced down
  logic [1:0]            loop_state;         // Loop power field
  logic                  loop_run;           // Loop may run
  logic                  loop_apd;           // Immediate power-down
  logic                  loop_spd;           // Synchronous power-down
  logic [13:0]           ref_count;          // Reference divider
  logic [5:0]            fb_pre;             // Prescale count
  logic [12:0]           fb_main;            // Main count
  logic                  ref_hold;           // Reference counter held
  logic                  fb_hold;            // Feedback counters held
  int                    fail_count = 0;     // Mismatches seen
  int                    compares   = 0;     // Comparisons made

  // Clock generator
  always #25 core_clk_i = ~core_clk_i;

  pll_divider_mode_registers i_dut (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .req_i             (req),
    .rvalid_o          (rvalid_o),
    .rdata_o           (rdata_o),
    .pump_drive_mode_o (pump_mode),
    .pump_hiz_o        (pump_hiz),
    .pump_force_src_o  (pump_src),
    .pump_force_sink_o (pump_sink),
    .loop_pwr_state_o  (loop_state),
    .loop_run_o        (loop_run),
    .loop_async_pd_o   (loop_apd),
    .loop_sync_pd_o    (loop_spd),
    .ref_div_count_o   (ref_count),
    .fb_prescale_o     (fb_pre),
    .fb_main_count_o   (fb_main),
    .ref_hold_rst_o    (ref_hold),
    .fb_hold_rst_o     (fb_hold)
  );

  // Prints the verdict and ends the run
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Single compare for every kind of result; case equality catches X
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Write one byte; an idle cycle follows so strobes never double up
  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    req.wr    = 1'b1;
    req.addr  = addr;
    req.wdata = data;
    @(posedge core_clk_i);
    #1;
    req.wr = 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask : wr

  // Read one byte; valid must stand exactly one cycle
  task automatic rd(input logic [9:0] addr, input logic [7:0] exp);
    req.rd   = 1'b1;
    req.addr = addr;
    @(posedge core_clk_i);
    #1;
    req.rd = 1'b0;
    chk(rvalid_o, 1'b1, "read valid");
    chk(rdata_o, exp, "read data");
    @(posedge core_clk_i);
    #1;
    chk(rvalid_o, 1'b0, "valid too long");
  endtask : rd

  // Reset values of every register and of the decoded outputs
  task automatic t_reset();
    logic [9:0] a [7] = '{10'h010, 10'h011, 10'h012, 10'h013, 10'h014,
                          10'h015, 10'h016};
    logic [7:0] v [7] = '{8'h7D, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
    chk(ref_count, 14'h0001, "ref reset");
    chk(fb_main, 13'h0003, "main reset");
    chk(fb_pre, 6'h00, "pre reset");
    chk({loop_run, loop_apd, loop_spd}, 3'h2, "loop reset");
    chk({pump_hiz, pump_src, pump_sink}, 3'h0, "pump reset");
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v[i]);
    end
  endtask : t_reset

  // Every pump mode and every loop power code, unused one included
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(10'h010, {4'h7, m[1:0], 2'h3});
      chk(pump_mode, m[1:0], "pump field");
      chk({pump_hiz, pump_src, pump_sink},
          {m == 0, m == 1, m == 2}, "pump decode");
    end
    for (int p = 0; p < 4; p++) begin
      wr(10'h010, {4'h7, 2'h3, p[1:0]});
      chk(loop_state, p[1:0], "loop field");
      chk({loop_run, loop_apd, loop_spd},
          {p == 0, p == 1 || p == 2, p == 3}, "loop decode");
    end
    rd(10'h010, 8'h7F);
  endtask : t_modes

  // Full-width divider values; reserved upper bits are dropped
  task automatic t_dividers();
    wr(10'h011, 8'hA5);
    wr(10'h012, 8'hFF);
    chk(ref_count, 14'h3FA5, "ref 14 bit");
    rd(10'h012, 8'h3F);
    wr(10'h013, 8'hFF);
    chk(fb_pre, 6'h3F, "prescale");
    rd(10'h013, 8'h3F);
    wr(10'h014, 8'h5A);
    wr(10'h015, 8'hFF);
    chk(fb_main, 13'h1F5A, "main 13 bit");
    rd(10'h015, 8'h1F);
    rd(10'h014, 8'h5A);
  endtask : t_dividers

  // Counter hold bits, each alone and together
  task automatic t_hold();
    logic [7:0] w [4] = '{8'h40, 8'h20, 8'h10, 8'h00};
    logic [1:0] e [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    for (int i = 0; i < 4; i++) begin
      wr(10'h016, w[i]);
      chk({ref_hold, fb_hold}, e[i], "hold bits");
    end
    wr(10'h016, 8'hFF);
    rd(10'h016, 8'h70);
  endtask : t_hold

  // Unmapped write is dropped and its read answers zero
  task automatic t_unmapped();
    wr(10'h020, 8'hAA);
    rd(10'h020, 8'h00);
    chk(ref_count, 14'h3FA5, "ref after stray");
  endtask : t_unmapped

  // Reset in mid-run brings the divider, pump and loop fields back to their defaults
  task automatic t_rerun();
    rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    chk(ref_count, 14'h0001, "ref rerun");
    chk(fb_main, 13'h0003, "main rerun");
    chk({fb_pre, pump_mode, loop_state}, 10'h00D, "mode rerun");
    rd(10'h010, 8'h7D);
  endtask : t_rerun

  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_modes();
    t_dividers();
    t_hold();
    t_unmapped();
    t_rerun();
    stop_test();
  end
endmodule : tb_top
